// ### hw/ccs_pkg.sv
// constants shared by the crt command and status unit
// assumes one character clock drives the whole unit
package ccs_pkg;

  // port select on the address line
  localparam logic       ADDR_PARAM     = 1'b0;
  localparam logic       ADDR_STATUS    = 1'b1;

  // command opcodes, matched on the top three bits
  localparam logic [2:0] OP_RESET       = 3'h0;
  localparam logic [2:0] OP_START       = 3'h1;
  localparam logic [2:0] OP_STOP        = 3'h2;
  localparam logic [2:0] OP_PEN         = 3'h3;
  localparam logic [2:0] OP_CURSOR      = 3'h4;
  localparam logic [2:0] OP_INT_ON      = 3'h5;
  localparam logic [2:0] OP_INT_OFF     = 3'h6;
  localparam logic [2:0] OP_PRESET      = 3'h7;

  // parameter byte counts
  localparam logic [2:0] RESET_PARAMS   = 3'h4;
  localparam logic [2:0] PEN_PARAMS     = 3'h2;
  localparam logic [2:0] CURSOR_PARAMS  = 3'h2;

  // status word bit positions
  localparam int         ST_IE          = 6;
  localparam int         ST_IR          = 5;
  localparam int         ST_LP          = 4;
  localparam int         ST_IC          = 3;
  localparam int         ST_VE          = 2;
  localparam int         ST_DU          = 1;
  localparam int         ST_FO          = 0;

  // start command field positions
  localparam int         START_SPACE_LSB = 2;
  localparam int         START_COUNT_LSB = 0;

  // reset values
  localparam logic [7:0] PARAM_RST      = 8'h00;
  localparam logic [6:0] FLAGS_RST      = 7'h00;

  // timing counts in character clocks
  localparam logic [1:0] PRESET_CLKS    = 2'h2;
  localparam logic [1:0] RUN_CLKS       = 2'h2;

  // states of the parameter sequencer
  typedef enum logic [1:0] {
    CCS_IDLE,
    CCS_RESET_SEQ,
    CCS_PEN_SEQ,
    CCS_CURSOR_SEQ
  } ccs_state_t;

  // character clocks between dma bursts
  function automatic logic [5:0] burst_gap(input logic [2:0] code);
    burst_gap = (code == 3'h0) ? 6'h00 : 6'({code, 3'h0} - 6'h01);
  endfunction

  // dma cycles per burst
  function automatic logic [3:0] burst_len(input logic [1:0] code);
    burst_len = 4'(4'h1 << code);
  endfunction

endpackage

// ### hw/ccs_format_decode.sv
// turns the packed screen-format bytes into registered counts
// assumes byte inputs come from flip-flops on the same clock
`timescale 1ns/10ps
module ccs_format_decode
(
  // clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       sys_rst_i,
  input  wire logic       ce_i,
  // packed parameters
  input  wire logic [7:0] byte1_i,
  input  wire logic [7:0] byte2_i,
  input  wire logic [7:0] byte3_i,
  input  wire logic [7:0] byte4_i,
  input  wire logic [2:0] space_code_i,
  input  wire logic [1:0] count_code_i,
  // decoded format
  output logic            spaced_rows_o,
  output logic [7:0]      chars_per_row_o,
  output logic [2:0]      vertical_retrace_rows_o,
  output logic [6:0]      rows_per_frame_o,
  output logic [4:0]      underline_line_o,
  output logic            blank_top_bottom_o,
  output logic [4:0]      lines_per_row_o,
  output logic            line_ctr_offset_o,
  output logic            field_attr_opaque_o,
  output logic            cursor_blink_o,
  output logic            cursor_underline_o,
  output logic [5:0]      horizontal_retrace_clocks_o,
  output logic [5:0]      burst_gap_o,
  output logic [3:0]      burst_len_o
);

  logic [49:0] dec_nxt;
  logic [49:0] dec_r;

  always_comb
  begin
    dec_nxt = dec_r;
    if (ce_i)
    begin
      // codes above 80 characters are left undefined, not clamped
      dec_nxt = {byte1_i[7],
                 8'({1'b0, byte1_i[6:0]} + 8'h01),
                 3'({1'b0, byte2_i[7:6]} + 3'h1),
                 7'({1'b0, byte2_i[5:0]} + 7'h01),
                 5'({1'b0, byte3_i[7:4]} + 5'h01),
                 byte3_i[7],
                 5'({1'b0, byte3_i[3:0]} + 5'h01),
                 byte4_i[7],
                 byte4_i[6],
                 ~byte4_i[5],
                 byte4_i[4],
                 6'({2'h0, byte4_i[3:0]} + 6'h01) << 1,
                 ccs_pkg::burst_gap(space_code_i),
                 ccs_pkg::burst_len(count_code_i)};
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
      dec_r <= 50'h0;
    else
      dec_r <= dec_nxt;
  end

  assign {spaced_rows_o, chars_per_row_o, vertical_retrace_rows_o, rows_per_frame_o,
          underline_line_o, blank_top_bottom_o, lines_per_row_o,
          line_ctr_offset_o, field_attr_opaque_o, cursor_blink_o,
          cursor_underline_o, horizontal_retrace_clocks_o, burst_gap_o, burst_len_o} = dec_r;

endmodule

// ### hw/ccs_pen_capture.sv
// synchronises the light pen pin and latches the raster position
// assumes position inputs are on the character clock
`timescale 1ns/10ps
module ccs_pen_capture
(
  // clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       sys_rst_i,
  input  wire logic       ce_i,
  // pen pin and raster position
  input  wire logic       light_pen_input_i,
  input  wire logic [7:0] raster_char_i,
  input  wire logic [7:0] raster_row_i,
  // captured position
  output logic [7:0]      pen_char_o,
  output logic [7:0]      pen_row_o,
  output logic            pen_loaded_o
);

  logic [2:0]  sync_r;
  logic [2:0]  sync_nxt;
  logic [16:0] cap_r;
  logic [16:0] cap_nxt;

  always_comb
  begin
    sync_nxt = sync_r;
    cap_nxt  = {1'b0, cap_r[15:0]};
    if (ce_i)
    begin
      sync_nxt = {sync_r[1:0], light_pen_input_i};
      // only a rising edge counts; a held pen does not retrigger
      if (sync_r[1] && !sync_r[2])
        cap_nxt = {1'b1, raster_char_i, raster_row_i};
    end
    else
      cap_nxt = cap_r;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      sync_r <= 3'h0;
      cap_r  <= 17'h0;
    end
    else
    begin
      sync_r <= sync_nxt;
      cap_r  <= cap_nxt;
    end
  end

  assign pen_loaded_o = cap_r[16];
  assign pen_char_o   = cap_r[15:8];
  assign pen_row_o    = cap_r[7:0];

endmodule

// ### hw/ccs_top.sv
// command decoder, parameter sequencer and status word of the crt unit
// assumes bus strobes and datapath events are single-cycle, same clock
//
// Summary of operation
// - seven-bit row length plus one, max 80
// - retrace rows and frame rows plus one
// - underline on field plus one line
// - underline top bit blanks edge lines
// - lines per row is field plus one
// - line offset mode and field attribute mode
// - two-bit cursor shape and blink decode
// - horizontal retrace is field plus one, doubled
// - burst gap zero or eight-step codes
// - burst length one, two, four, eight
// - start enables interrupts, dma and video
// - stop clears video only
// - pen command feeds two parameter reads
// - cursor command loads two written bytes
// - interrupt enable and disable commands
// - preset holds counters, two clocks to preset, three to first char
// - last row sets request when enabled
// - pen capture sets pen flag
// - wrong parameter count sets bad flag
// - video flag set by start, cleared by stop and reset
// - underrun stops dma, blanks to retrace
// - fifo overrun sets overflow flag
// - address line selects parameter or status
// - reset command stops dma, interrupts, video
// - early command marks previous improper
`timescale 1ns/10ps
module ccs_top
(
  // clock, reset, enable
  input  wire logic       clk_sys_i,
  input  wire logic       sys_rst_i,
  input  wire logic       ce_i,
  // processor port
  input  wire logic       addr_i,
  input  wire logic       rd_stb_i,
  input  wire logic       wr_stb_i,
  input  wire logic [7:0] data_i,
  output logic [7:0]      data_o,
  output logic            data_oe_o,
  // datapath and timing events
  input  wire logic       last_row_start_i,
  input  wire logic       vertical_retrace_end_i,
  input  wire logic       dma_underrun_i,
  input  wire logic       fifo_overrun_i,
  input  wire logic       light_pen_input_i,
  input  wire logic [7:0] raster_char_i,
  input  wire logic [7:0] raster_row_i,
  // control to the display engine
  output logic            dma_enable_o,
  output logic            video_suppress_o,
  output logic            frame_end_pending_o,
  output logic            counter_preset_o,
  output logic            first_char_o,
  output logic [7:0]      cursor_char_o,
  output logic [7:0]      cursor_row_o,
  // decoded screen format
  output logic            spaced_rows_o,
  output logic [7:0]      chars_per_row_o,
  output logic [2:0]      vertical_retrace_rows_o,
  output logic [6:0]      rows_per_frame_o,
  output logic [4:0]      underline_line_o,
  output logic            blank_top_bottom_o,
  output logic [4:0]      lines_per_row_o,
  output logic            line_ctr_offset_o,
  output logic            field_attr_opaque_o,
  output logic            cursor_blink_o,
  output logic            cursor_underline_o,
  output logic [5:0]      horizontal_retrace_clocks_o,
  output logic [5:0]      burst_gap_o,
  output logic [3:0]      burst_len_o
);

  logic cmd_wr;
  logic par_wr;
  logic par_rd;
  logic sts_rd;
  assign cmd_wr = ce_i && wr_stb_i && (addr_i == ccs_pkg::ADDR_STATUS);
  assign par_wr = ce_i && wr_stb_i && (addr_i == ccs_pkg::ADDR_PARAM);
  assign sts_rd = ce_i && rd_stb_i && (addr_i == ccs_pkg::ADDR_STATUS);
  assign par_rd = ce_i && rd_stb_i && (addr_i == ccs_pkg::ADDR_PARAM);

  logic [2:0] opcode;
  assign opcode = data_i[7:5];

  logic [7:0] pen_char;
  logic [7:0] pen_row;
  logic       pen_loaded;

  // sequencer and parameter storage
  ccs_pkg::ccs_state_t state_r;
  ccs_pkg::ccs_state_t state_nxt;
  logic [2:0]          pidx_r;
  logic [2:0]          pidx_nxt;
  logic [7:0]          byte_r   [4];
  logic [7:0]          byte_nxt [4];
  logic [7:0]          cur_char_r;
  logic [7:0]          cur_char_nxt;
  logic [7:0]          cur_row_r;
  logic [7:0]          cur_row_nxt;
  logic [2:0]          space_r;
  logic [2:0]          space_nxt;
  logic [1:0]          count_r;
  logic [1:0]          count_nxt;
  logic                bad_evt;

  always_comb
  begin
    state_nxt    = state_r;
    pidx_nxt     = pidx_r;
    byte_nxt     = byte_r;
    cur_char_nxt = cur_char_r;
    cur_row_nxt  = cur_row_r;
    space_nxt    = space_r;
    count_nxt    = count_r;
    bad_evt      = 1'b0;
    if (cmd_wr)
    begin
      bad_evt   = (state_r != ccs_pkg::CCS_IDLE);
      pidx_nxt  = 3'h0;
      state_nxt = ccs_pkg::CCS_IDLE;
      case (opcode)
        ccs_pkg::OP_RESET:  state_nxt = ccs_pkg::CCS_RESET_SEQ;
        ccs_pkg::OP_PEN:    state_nxt = ccs_pkg::CCS_PEN_SEQ;
        ccs_pkg::OP_CURSOR: state_nxt = ccs_pkg::CCS_CURSOR_SEQ;
        ccs_pkg::OP_START:
        begin
          space_nxt = data_i[ccs_pkg::START_SPACE_LSB +: 3];
          count_nxt = data_i[ccs_pkg::START_COUNT_LSB +: 2];
        end
        default:            state_nxt = ccs_pkg::CCS_IDLE;
      endcase
    end
    else if (par_wr)
    begin
      case (state_r)
        ccs_pkg::CCS_RESET_SEQ:
        begin
          byte_nxt[pidx_r[1:0]] = data_i;
          pidx_nxt = 3'(pidx_r + 3'h1);
          if (pidx_nxt == ccs_pkg::RESET_PARAMS)
            state_nxt = ccs_pkg::CCS_IDLE;
        end
        ccs_pkg::CCS_CURSOR_SEQ:
        begin
          if (pidx_r == 3'h0)
            cur_char_nxt = data_i;
          else
            cur_row_nxt = data_i;
          pidx_nxt = 3'(pidx_r + 3'h1);
          if (pidx_nxt == ccs_pkg::CURSOR_PARAMS)
            state_nxt = ccs_pkg::CCS_IDLE;
        end
        default: bad_evt = 1'b1;
      endcase
    end
    else if (par_rd)
    begin
      // two reads drain the pen position
      if (state_r == ccs_pkg::CCS_PEN_SEQ)
      begin
        pidx_nxt = 3'(pidx_r + 3'h1);
        if (pidx_nxt == ccs_pkg::PEN_PARAMS)
          state_nxt = ccs_pkg::CCS_IDLE;
      end
      else
        bad_evt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      state_r    <= ccs_pkg::CCS_IDLE;
      pidx_r     <= 3'h0;
      byte_r     <= '{default: ccs_pkg::PARAM_RST};
      cur_char_r <= ccs_pkg::PARAM_RST;
      cur_row_r  <= ccs_pkg::PARAM_RST;
      space_r    <= 3'h0;
      count_r    <= 2'h0;
    end
    else
    begin
      state_r    <= state_nxt;
      pidx_r     <= pidx_nxt;
      byte_r     <= byte_nxt;
      cur_char_r <= cur_char_nxt;
      cur_row_r  <= cur_row_nxt;
      space_r    <= space_nxt;
      count_r    <= count_nxt;
    end
  end

  // flags, dma gate, readback
  logic       ie_r, ir_r, lp_r, ic_r, ve_r, du_r, fo_r;
  logic       ie_nxt, ir_nxt, lp_nxt, ic_nxt, ve_nxt, du_nxt, fo_nxt;
  logic       dma_r;
  logic       dma_nxt;
  logic       blank_r;
  logic       blank_nxt;
  logic [7:0] rdat_r;
  logic [7:0] rdat_nxt;
  logic       roe_r;
  logic       roe_nxt;
  logic [6:0] flags;
  assign flags = {ie_r, ir_r, lp_r, ic_r, ve_r, du_r, fo_r};

  always_comb
  begin
    {ie_nxt, ir_nxt, lp_nxt, ic_nxt, ve_nxt, du_nxt, fo_nxt} = flags;
    dma_nxt   = dma_r;
    blank_nxt = blank_r;
    rdat_nxt  = rdat_r;
    roe_nxt   = 1'b0;
    if (ce_i)
    begin
      // read clears the event flags; a same-cycle event still sets below
      if (sts_rd)
      begin
        ir_nxt = 1'b0;
        lp_nxt = 1'b0;
        ic_nxt = 1'b0;
        du_nxt = 1'b0;
        fo_nxt = 1'b0;
      end
      if (cmd_wr)
      begin
        case (opcode)
          ccs_pkg::OP_RESET:
          begin
            ie_nxt  = 1'b0;
            ve_nxt  = 1'b0;
            dma_nxt = 1'b0;
          end
          ccs_pkg::OP_START:
          begin
            ie_nxt  = 1'b1;
            ve_nxt  = 1'b1;
            dma_nxt = 1'b1;
          end
          ccs_pkg::OP_STOP:    ve_nxt = 1'b0;
          ccs_pkg::OP_INT_ON:  ie_nxt = 1'b1;
          ccs_pkg::OP_INT_OFF: ie_nxt = 1'b0;
          default:             ie_nxt = ie_r;
        endcase
      end
      // frame end request gated by enable
      if (last_row_start_i && ie_r)
        ir_nxt = 1'b1;
      if (pen_loaded)
        lp_nxt = 1'b1;
      if (bad_evt)
        ic_nxt = 1'b1;
      // retrace end releases the blank before a new underrun can reassert it
      if (vertical_retrace_end_i)
        blank_nxt = 1'b0;
      if (dma_underrun_i)
      begin
        du_nxt    = 1'b1;
        dma_nxt   = 1'b0;
        blank_nxt = 1'b1;
      end
      if (fifo_overrun_i)
        fo_nxt = 1'b1;
      // status word with zero top bit
      if (sts_rd)
      begin
        rdat_nxt = {1'b0, flags};
        roe_nxt  = 1'b1;
      end
      else if (par_rd)
      begin
        roe_nxt  = 1'b1;
        rdat_nxt = 8'h00;
        if (state_r == ccs_pkg::CCS_PEN_SEQ)
          rdat_nxt = (pidx_r == 3'h0) ? pen_char : pen_row;
      end
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      {ie_r, ir_r, lp_r, ic_r, ve_r, du_r, fo_r} <= ccs_pkg::FLAGS_RST;
      dma_r   <= 1'b0;
      blank_r <= 1'b0;
      rdat_r  <= 8'h00;
      roe_r   <= 1'b0;
    end
    else
    begin
      {ie_r, ir_r, lp_r, ic_r, ve_r, du_r, fo_r} <=
        {ie_nxt, ir_nxt, lp_nxt, ic_nxt, ve_nxt, du_nxt, fo_nxt};
      dma_r   <= dma_nxt;
      blank_r <= blank_nxt;
      rdat_r  <= rdat_nxt;
      roe_r   <= roe_nxt;
    end
  end

  // preset of the timing counters
  logic       hold_r;
  logic       hold_nxt;
  logic [1:0] pcnt_r;
  logic [1:0] pcnt_nxt;
  logic [1:0] rcnt_r;
  logic [1:0] rcnt_nxt;
  logic       fc_r;
  logic       fc_nxt;

  always_comb
  begin
    hold_nxt = hold_r;
    pcnt_nxt = pcnt_r;
    rcnt_nxt = rcnt_r;
    fc_nxt   = fc_r;
    if (ce_i)
    begin
      fc_nxt = (rcnt_r == 2'h1);
      if (pcnt_r != 2'h0)
        pcnt_nxt = 2'(pcnt_r - 2'h1);
      if (rcnt_r != 2'h0)
        rcnt_nxt = 2'(rcnt_r - 2'h1);
      if (cmd_wr && (opcode == ccs_pkg::OP_PRESET))
      begin
        hold_nxt = 1'b1;
        pcnt_nxt = 2'(ccs_pkg::PRESET_CLKS - 2'h1);
        rcnt_nxt = 2'h0;
      end
      else if (cmd_wr && hold_r)
      begin
        hold_nxt = 1'b0;
        rcnt_nxt = ccs_pkg::RUN_CLKS;
      end
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      hold_r <= 1'b0;
      pcnt_r <= 2'h0;
      rcnt_r <= 2'h0;
      fc_r   <= 1'b0;
    end
    else
    begin
      hold_r <= hold_nxt;
      pcnt_r <= pcnt_nxt;
      rcnt_r <= rcnt_nxt;
      fc_r   <= fc_nxt;
    end
  end

  assign data_o              = rdat_r;
  assign data_oe_o           = roe_r;
  assign dma_enable_o        = dma_r;
  assign video_suppress_o    = !ve_r || blank_r;
  assign frame_end_pending_o = ir_r;
  assign counter_preset_o    = hold_r && (pcnt_r == 2'h0);
  assign first_char_o        = fc_r;
  assign cursor_char_o       = cur_char_r;
  assign cursor_row_o        = cur_row_r;

  ccs_pen_capture u_pen
  (
    .clk_sys_i         (clk_sys_i),
    .sys_rst_i         (sys_rst_i),
    .ce_i              (ce_i),
    .light_pen_input_i (light_pen_input_i),
    .raster_char_i     (raster_char_i),
    .raster_row_i      (raster_row_i),
    .pen_char_o        (pen_char),
    .pen_row_o         (pen_row),
    .pen_loaded_o      (pen_loaded)
  );

  ccs_format_decode u_fmt
  (
    .clk_sys_i           (clk_sys_i),
    .sys_rst_i           (sys_rst_i),
    .ce_i                (ce_i),
    .byte1_i             (byte_r[0]),
    .byte2_i             (byte_r[1]),
    .byte3_i             (byte_r[2]),
    .byte4_i             (byte_r[3]),
    .space_code_i        (space_r),
    .count_code_i        (count_r),
    .spaced_rows_o       (spaced_rows_o),
    .chars_per_row_o     (chars_per_row_o),
    .vertical_retrace_rows_o         (vertical_retrace_rows_o),
    .rows_per_frame_o    (rows_per_frame_o),
    .underline_line_o    (underline_line_o),
    .blank_top_bottom_o  (blank_top_bottom_o),
    .lines_per_row_o     (lines_per_row_o),
    .line_ctr_offset_o   (line_ctr_offset_o),
    .field_attr_opaque_o (field_attr_opaque_o),
    .cursor_blink_o      (cursor_blink_o),
    .cursor_underline_o  (cursor_underline_o),
    .horizontal_retrace_clocks_o       (horizontal_retrace_clocks_o),
    .burst_gap_o         (burst_gap_o),
    .burst_len_o         (burst_len_o)
  );

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  chk_start_flags: assert property (cmd_wr && opcode == ccs_pkg::OP_START
    |=> ie_r && ve_r && dma_r) else $error("start did not enable");
  chk_stop_video: assert property (cmd_wr && opcode == ccs_pkg::OP_STOP
    |=> !ve_r && video_suppress_o && ie_r == $past(ie_r)) else $error("stop wrong");
  chk_reset_cmd: assert property (cmd_wr && opcode == ccs_pkg::OP_RESET
    |=> !dma_r && !ie_r && video_suppress_o) else $error("reset cmd wrong");
  chk_status_layout: assert property (sts_rd
    |=> data_oe_o && data_o == {1'b0, $past(flags)}) else $error("status word wrong");
  chk_frame_irq: assert property (ce_i && last_row_start_i && ie_r
    |=> ir_r) else $error("request not set");
  chk_early_cmd: assert property (cmd_wr && state_r != ccs_pkg::CCS_IDLE
    |=> ic_r) else $error("improper not flagged");
  chk_underrun_stop: assert property (ce_i && dma_underrun_i
    |=> du_r && !dma_r && video_suppress_o) else $error("underrun not handled");
  chk_overrun_flag: assert property (ce_i && fifo_overrun_i
    |=> fo_r) else $error("overrun not flagged");
  chk_preset_hold: assert property (cmd_wr && opcode == ccs_pkg::OP_PRESET
    ##1 ce_i ##1 1'b1 |-> counter_preset_o) else $error("preset late");
  chk_pen_readback: assert property (par_rd && state_r == ccs_pkg::CCS_PEN_SEQ
    && pidx_r == 3'h0 |=> data_o == $past(pen_char)) else $error("pen char wrong");

  cov_start: cover property (cmd_wr && opcode == ccs_pkg::OP_START);
  cov_reset_done: cover property (par_wr && state_r == ccs_pkg::CCS_RESET_SEQ
    && pidx_r == 3'h3);
  cov_pen_read: cover property (par_rd && state_r == ccs_pkg::CCS_PEN_SEQ);
  cov_underrun: cover property (ce_i && dma_underrun_i ##[1:20] vertical_retrace_end_i);

endmodule

// ### bench/ccs_host_model.sv
// processor model that drives the unit's parameter and command ports
// assumes the bench waits for read answers itself; no stall on this bus
`timescale 1ns/10ps
module ccs_host_model
(
  // clock
  input  wire logic       clk_sys_i,
  // processor port
  output logic            addr_o,
  output logic            rd_stb_o,
  output logic            wr_stb_o,
  output logic [7:0]      data_o
);
  initial
  begin
    addr_o   = 1'b0;
    rd_stb_o = 1'b0;
    wr_stb_o = 1'b0;
    data_o   = 8'h00;
  end

  task automatic access(input logic a, input logic w, input logic [7:0] d);
    @(negedge clk_sys_i);
    addr_o   = a;
    wr_stb_o = w;
    rd_stb_o = !w;
    data_o   = d;
    @(negedge clk_sys_i);
    wr_stb_o = 1'b0;
    rd_stb_o = 1'b0;
    // a released bus must not keep showing the last byte
    data_o   = ~d;
  endtask
endmodule

// ### bench/ccs_top_tb_top.sv
// self-checking bench for the crt command and status unit
// assumes the host model owns the processor port strobes
`timescale 1ns/10ps
module ccs_top_tb_top;
  logic       clk_sys_i = 1'b0;
  logic       sys_rst_i = 1'b1;
  logic       ce_i = 1'b1;
  logic       last_row_start_i = 1'b0, vertical_retrace_end_i = 1'b0;
  logic       dma_underrun_i = 1'b0, fifo_overrun_i = 1'b0, light_pen_input_i = 1'b0;
  logic [7:0] raster_char_i = 8'h00, raster_row_i = 8'h00;
  logic       addr_i, rd_stb_i, wr_stb_i, data_oe_o, dma_enable_o, video_suppress_o;
  logic       frame_end_pending_o, counter_preset_o, first_char_o, spaced_rows_o;
  logic       blank_top_bottom_o, line_ctr_offset_o, field_attr_opaque_o;
  logic       cursor_blink_o, cursor_underline_o;
  logic [7:0] data_i, data_o, cursor_char_o, cursor_row_o, chars_per_row_o;
  logic [2:0] vertical_retrace_rows_o;
  logic [6:0] rows_per_frame_o;
  logic [4:0] underline_line_o, lines_per_row_o;
  logic [5:0] horizontal_retrace_clocks_o, burst_gap_o;
  logic [3:0] burst_len_o;
  int         failures = 0, num_checks = 0;
  logic [7:0] exp_q[$];

  always #4 clk_sys_i = ~clk_sys_i;

  ccs_host_model u_host (.clk_sys_i, .addr_o(addr_i), .rd_stb_o(rd_stb_i),
                         .wr_stb_o(wr_stb_i), .data_o(data_i));
  ccs_top uut (.clk_sys_i, .sys_rst_i, .ce_i, .addr_i, .rd_stb_i, .wr_stb_i, .data_i,
    .data_o, .data_oe_o, .last_row_start_i, .vertical_retrace_end_i, .dma_underrun_i,
    .fifo_overrun_i, .light_pen_input_i, .raster_char_i, .raster_row_i, .dma_enable_o,
    .video_suppress_o, .frame_end_pending_o, .counter_preset_o, .first_char_o,
    .cursor_char_o, .cursor_row_o, .spaced_rows_o, .chars_per_row_o, .vertical_retrace_rows_o,
    .rows_per_frame_o, .underline_line_o, .blank_top_bottom_o, .lines_per_row_o,
    .line_ctr_offset_o, .field_attr_opaque_o, .cursor_blink_o, .cursor_underline_o,
    .horizontal_retrace_clocks_o, .burst_gap_o, .burst_len_o);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %0h exp %0h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (failures == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic wr(input logic a, input logic [7:0] d);
    u_host.access(a, 1'b1, d);
  endtask

  // read answers are noted here and matched by the monitor below
  task automatic rd(input logic a, input logic [7:0] e);
    exp_q.push_back(e);
    u_host.access(a, 1'b0, 8'h00);
    repeat (2) @(negedge clk_sys_i);
  endtask

  // one-cycle event pulses: last row, retrace end, underrun, overrun
  task automatic ev(input logic [3:0] m);
    @(negedge clk_sys_i);
    {last_row_start_i, vertical_retrace_end_i, dma_underrun_i, fifo_overrun_i} = m;
    @(negedge clk_sys_i);
    {last_row_start_i, vertical_retrace_end_i, dma_underrun_i, fifo_overrun_i} = 4'h0;
  endtask

  // sampled mid-cycle so the registered answer is settled
  always @(negedge clk_sys_i)
    if (data_oe_o === 1'b1)
      chk(data_o, exp_q.size() > 0 ? {24'h0, exp_q.pop_front()} : 32'h100);

  initial
  begin
    #100000;
    failures++;
    tally_and_finish();
  end

  initial
  begin
    logic [7:0] b [4];
    logic [7:0] c, r;
    int         n;
    void'($urandom(31));
    repeat (20) @(posedge clk_sys_i);
    @(negedge clk_sys_i) sys_rst_i = 1'b0;
    repeat (4)
    begin
      wr(1'b1, 8'h00);
      foreach (b[i])
      begin
        b[i] = 8'($urandom);
        if (i == 0)
          b[i][6:0] = 7'($urandom_range(79));
        wr(1'b0, b[i]);
      end
      repeat (3) @(negedge clk_sys_i);
      chk(chars_per_row_o, b[0][6:0] + 8'h01);
      chk(spaced_rows_o, b[0][7]);
      chk({vertical_retrace_rows_o, rows_per_frame_o}, {b[1][7:6] + 3'h1, b[1][5:0] + 7'h01});
      chk(underline_line_o, b[2][7:4] + 5'h01);
      chk(blank_top_bottom_o, b[2][7]);
      chk(lines_per_row_o, b[2][3:0] + 5'h01);
      chk({line_ctr_offset_o, field_attr_opaque_o}, b[3][7:6]);
      chk({cursor_blink_o, cursor_underline_o}, {!b[3][5], b[3][4]});
      chk(horizontal_retrace_clocks_o, {b[3][3:0] + 5'h01, 1'b0});
      rd(1'b1, 8'h00);
    end
    for (int s = 0; s < 8; s++)
      for (int k = 0; k < 4; k++)
      begin
        wr(1'b1, {3'h1, 3'(s), 2'(k)});
        repeat (3) @(negedge clk_sys_i);
        chk(burst_gap_o, s != 0 ? 8 * s - 1 : 0);
        chk(burst_len_o, 1 << k);
      end
    chk({dma_enable_o, video_suppress_o}, 2'h2);
    rd(1'b1, 8'h44);
    ev(4'h8);
    chk(frame_end_pending_o, 1'b1);
    ev(4'h1);
    ev(4'h2);
    chk({dma_enable_o, video_suppress_o}, 2'h1);
    rd(1'b1, 8'h67);
    rd(1'b1, 8'h44);
    chk(frame_end_pending_o, 1'b0);
    ev(4'h4);
    @(negedge clk_sys_i);
    chk(video_suppress_o, 1'b0);
    wr(1'b1, 8'h40);
    rd(1'b1, 8'h40);
    wr(1'b1, 8'hC0);
    ev(4'h8);
    chk(frame_end_pending_o, 1'b0);
    rd(1'b1, 8'h00);
    wr(1'b1, 8'hA0);
    rd(1'b1, 8'h40);
    c = 8'($urandom);
    r = 8'($urandom);
    wr(1'b1, 8'h80);
    wr(1'b0, c);
    wr(1'b0, r);
    wr(1'b0, r);
    chk({cursor_char_o, cursor_row_o}, {c, r});
    rd(1'b1, 8'h48);
    wr(1'b1, 8'h00);
    wr(1'b0, 8'h00);
    wr(1'b1, 8'h40);
    chk({dma_enable_o, video_suppress_o}, 2'h1);
    rd(1'b1, 8'h08);
    raster_char_i = c;
    raster_row_i = r;
    light_pen_input_i = 1'b1;
    repeat (8) @(negedge clk_sys_i);
    light_pen_input_i = 1'b0;
    rd(1'b1, 8'h10);
    wr(1'b1, 8'h60);
    rd(1'b0, c);
    rd(1'b0, r);
    rd(1'b1, 8'h00);
    wr(1'b1, 8'hE0);
    repeat (3) @(negedge clk_sys_i);
    chk(counter_preset_o, 1'b1);
    wr(1'b1, 8'hA0);
    n = 0;
    repeat (6) @(negedge clk_sys_i) n += (first_char_o === 1'b1);
    chk({counter_preset_o, 8'(n)}, 9'h001);
    tally_and_finish();
  end
endmodule
